// >>> bas_defs.vh
`ifndef BAS_DEFS_VH
`define BAS_DEFS_VH
// operation select codes
`define BAS_OP_W 3
`define BAS_OP_NONE 3'h0
`define BAS_OP_SUB 3'h1
`define BAS_OP_RRC 3'h2
`define BAS_OP_SWAP 3'h3
`define BAS_OP_DIR 3'h4
`define BAS_OP_XORL 3'h5
`define BAS_OP_XORF 3'h6
// operand fields
`define BAS_FA_W 5
`define BAS_DEST_W 1'b0
`define BAS_DEST_F 1'b1
// direction register selectors
`define BAS_DIR_A 5'h06
`define BAS_DIR_B 5'h07
// reset values
`define BAS_W_RST 8'h00
`define BAS_DIR_RST 8'hff
`define BAS_ADDR_RST 5'h00
`define BAS_ZERO8 8'h00
// arithmetic constants for the subtract path
`define BAS_ONE9 9'h001
`define BAS_ONE5 5'h01
`endif

// >>> bas_alu.v
`timescale 1ns/1ps
`include "bas_defs.vh"
// What this block does
// RULE1 - subtract computes file minus working register; updates carry, digit carry, zero
// RULE2 - destination bit 0 writes working register, 1 writes back the file register
// RULE3 - rotate right through carry: old carry to bit 7, bit 0 to carry
// RULE4 - nibble swap exchanges upper and lower halves, no flags change
// RULE5 - tristate load copies working register into direction register 6 or 7
// RULE6 - literal xor combines working register with immediate into working register, zero flag
// RULE7 - register xor combines working register with file, destination bit chooses, zero only
// RULE8 - zero flag set when 8-bit result is zero, cleared otherwise
module bas_alu (
  // clock and reset
  input wire i_mclk,
  input wire i_rst_n,
  // operation from decode, one cycle pulse in i_op_valid
  input wire i_op_valid,
  input wire [2:0] i_op,
  input wire [4:0] i_faddr,
  input wire i_dest,
  input wire [7:0] i_literal,
  // operand read from file space and current flags
  input wire [7:0] i_fdata,
  input wire i_carry,
  input wire i_digit_carry,
  input wire i_zero,
  // file write back
  output reg o_fwr,
  output reg [4:0] o_fwr_addr,
  output reg [7:0] o_fwr_data,
  // flags out with update strobe
  output reg o_flag_wr,
  output reg o_carry,
  output reg o_digit_carry_flag,
  output reg o_zero,
  // working and direction registers
  output reg [7:0] o_wreg,
  output reg [7:0] o_dir_a,
  output reg [7:0] o_dir_b
);
  // reset release stage; the datapath only ever sees the second flop
  reg rst_s1_q;
  reg rst_s2_q;
  // result and flag next values from the operation decode
  reg [7:0] res_d;
  reg carry_d;
  reg digit_d;
  reg zero_d;
  reg upd_d;
  reg dest_sel_d;
  // subtract intermediates: whole byte and low nibble, each with carry out
  reg [8:0] diff;
  reg [4:0] ndiff;
  // commit strobes for the registered ports
  reg fwr_d;
  reg wwr_d;
  reg flg_d;
  reg dir_a_d;
  reg dir_b_d;

  // zero detect shared by every op that touches the zero flag
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == `BAS_ZERO8); // [RULE8]
    end
  endfunction

  // direction load hit for one selector; other selectors fall through silently
  function dir_hit;
    input valid;
    input [2:0] op;
    input [4:0] faddr;
    input [4:0] sel;
    begin
      dir_hit = valid && (op == `BAS_OP_DIR) && (faddr == sel); // [RULE5]
    end
  endfunction

  // reset release through two flops; assertion stays asynchronous so a
  // clean release is all that the flops have to provide
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // subtract arithmetic; carry means no borrow, as in adding the negation
  // of the working register plus one
  always @* begin
    diff = {1'b0, i_fdata} + {1'b0, ~o_wreg} + `BAS_ONE9;
    // nibble carry out gives the digit carry
    ndiff = {1'b0, i_fdata[3:0]} + {1'b0, ~o_wreg[3:0]} + `BAS_ONE5;
  end

  // result and flag calculation; flags an op leaves alone keep the incoming
  // value, so the flag store can take all three on every update strobe
  always @* begin
    res_d = `BAS_ZERO8;
    carry_d = i_carry;
    digit_d = i_digit_carry;
    zero_d = i_zero;
    upd_d = 1'b0;
    dest_sel_d = i_dest;
    case (i_op)
      `BAS_OP_SUB: begin
        // all three flags follow the subtraction
        res_d = diff[7:0]; // [RULE1]
        carry_d = diff[8];
        digit_d = ndiff[4];
        zero_d = is_zero(diff[7:0]);
        upd_d = 1'b1;
      end
      `BAS_OP_RRC: begin
        // old carry enters the top, bit 0 leaves into carry
        res_d = {i_carry, i_fdata[7:1]}; // [RULE3]
        carry_d = i_fdata[0];
        upd_d = 1'b1;
      end
      `BAS_OP_SWAP: begin
        // every flag echoed unchanged
        res_d = {i_fdata[3:0], i_fdata[7:4]}; // [RULE4]
        upd_d = 1'b1;
      end
      `BAS_OP_XORL: begin
        res_d = o_wreg ^ i_literal; // [RULE6]
        zero_d = is_zero(o_wreg ^ i_literal);
        dest_sel_d = `BAS_DEST_W; // literal form always targets the working register
        upd_d = 1'b1;
      end
      `BAS_OP_XORF: begin
        // carry and digit carry echoed, destination bit chooses the target
        res_d = o_wreg ^ i_fdata; // [RULE7]
        zero_d = is_zero(o_wreg ^ i_fdata);
        upd_d = 1'b1;
      end
      default: begin
        // no-op codes and the direction load produce no result
        res_d = `BAS_ZERO8;
      end
    endcase
  end

  // commit strobes; a cleared valid or a no-op code writes nothing
  always @* begin
    fwr_d = 1'b0;
    wwr_d = 1'b0;
    flg_d = i_op_valid && upd_d;
    if (i_op_valid && upd_d) begin
      if (dest_sel_d == `BAS_DEST_F)
        fwr_d = 1'b1; // [RULE2]
      else
        wwr_d = 1'b1; // [RULE2]
    end
    dir_a_d = dir_hit(i_op_valid, i_op, i_faddr, `BAS_DIR_A);
    dir_b_d = dir_hit(i_op_valid, i_op, i_faddr, `BAS_DIR_B);
  end

  // file write port; the strobe is a single-cycle pulse, address and data
  // hold so the far side may latch them a little late
  always @(posedge i_mclk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      o_fwr <= 1'b0;
      o_fwr_addr <= `BAS_ADDR_RST;
      o_fwr_data <= `BAS_ZERO8;
    end else begin
      o_fwr <= fwr_d;
      if (fwr_d) begin
        o_fwr_addr <= i_faddr;
        o_fwr_data <= res_d;
      end
    end
  end

  // flag port; the far side must feed back what it stores before the next
  // op reads i_carry, else a back-to-back rotate sees a stale carry
  always @(posedge i_mclk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      o_flag_wr <= 1'b0;
      o_carry <= 1'b0;
      o_digit_carry_flag <= 1'b0;
      o_zero <= 1'b0;
    end else begin
      o_flag_wr <= flg_d;
      if (flg_d) begin
        o_carry <= carry_d;
        o_digit_carry_flag <= digit_d;
        o_zero <= zero_d; // [RULE8]
      end
    end
  end

  // working register; the next op already sees the updated value
  always @(posedge i_mclk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      o_wreg <= `BAS_W_RST;
    end else begin
      if (wwr_d) begin
        o_wreg <= res_d; // [RULE2]
      end
    end
  end

  // direction registers; reset to all ones so every port pin starts as input
  always @(posedge i_mclk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      o_dir_a <= `BAS_DIR_RST;
      o_dir_b <= `BAS_DIR_RST;
    end else begin
      if (dir_a_d) begin
        o_dir_a <= o_wreg; // [RULE5]
      end
      if (dir_b_d) begin
        o_dir_b <= o_wreg; // [RULE5]
      end
    end
  end
endmodule

// >>> bas_alu_asserts.sv
`timescale 1ns/1ps
module bas_alu_asserts (
  input wire i_mclk, i_rst_n, i_op_valid, i_dest, i_carry, i_zero, o_fwr, o_carry, o_zero,
  input wire [2:0] i_op,
  input wire [4:0] i_faddr, o_fwr_addr,
  input wire [7:0] i_fdata, i_literal, o_fwr_data, o_wreg, o_dir_a
);
  // valid and code together, so a no-op never matches
  wire [3:0] v = {i_op_valid, i_op};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_sub_val: assert property (v == 9 && i_dest |=> o_fwr_data == $past(i_fdata) - $past(o_wreg)) else $error("sub");
  a_sub_cy: assert property (v == 9 |=> o_carry == ($past(i_fdata) >= $past(o_wreg))) else $error("borrow");
  a_dest_w: assert property (i_op_valid && !i_dest |=> !o_fwr) else $error("dest");
  a_dest_f: assert property (i_op_valid && i_dest && (i_op == 1 || i_op == 2 || i_op == 3 || i_op == 6)
    |=> o_fwr && o_fwr_addr == $past(i_faddr)) else $error("file dest");
  a_swap_flg: assert property (v == 11 |=> o_carry == $past(i_carry) && o_zero == $past(i_zero)) else $error("swap flags");
  a_rot_cy: assert property (v == 10 |=> o_carry == $past(i_fdata[0])) else $error("rotate");
  a_swap_val: assert property (v == 11 && i_dest |=> o_fwr_data == {$past(i_fdata[3:0]), $past(i_fdata[7:4])}) else $error("swap");
  a_dir_ld: assert property (v == 12 && i_faddr == 6 |=> o_dir_a == $past(o_wreg)) else $error("dir");
  a_xorl_val: assert property (v == 13 |=> o_wreg == ($past(o_wreg) ^ $past(i_literal))) else $error("xorl");
  a_zero_set: assert property (v == 13 |=> o_zero == (o_wreg == 0)) else $error("zero");
  a_xorf_cy: assert property (v == 14 |=> o_carry == $past(i_carry)) else $error("xorf");
endmodule
bind bas_alu bas_alu_asserts i_bas_alu_asserts (.*);

// >>> bas_file_model.sv
`timescale 1ns/1ps
module bas_file_model (
  input wire i_mclk, i_fwr, i_flag_wr,
  input wire [4:0] i_faddr, i_fwr_addr,
  input wire [7:0] i_fwr_data,
  input wire [2:0] i_flags,
  output wire [7:0] o_fdata,
  output wire [2:0] o_flags
);
  reg [7:0] m [0:31];
  reg [2:0] f = 0;
  integer j;
  // file preset to 37 times the address
  initial for (j = 0; j < 32; j = j + 1) m[j] = j * 37;
  assign o_fdata = m[i_faddr];
  // new flags pass straight on, else the next op would see stale ones
  assign o_flags = i_flag_wr ? i_flags : f;
  always @(posedge i_mclk) begin
    if (i_fwr) m[i_fwr_addr] <= i_fwr_data;
    if (i_flag_wr) f <= i_flags;
  end
endmodule

// >>> bas_alu_test.sv
`timescale 1ns/1ps
module bas_alu_test;
  reg c = 0, r = 0, v = 0, d = 0;
  reg [2:0] op = 0;
  reg [4:0] a = 0;
  reg [7:0] k = 0;
  wire fw, fl, oc, od, oz;
  wire [2:0] fg;
  wire [4:0] fa;
  wire [7:0] fd, wd, ow, ta, tb;
  integer bad_count = 0, check_count = 0;
  bas_alu i_bas_alu (.i_mclk(c), .i_rst_n(r), .i_op_valid(v), .i_op(op), .i_faddr(a), .i_dest(d),
    .i_literal(k), .i_fdata(fd), .i_carry(fg[2]), .i_digit_carry(fg[1]), .i_zero(fg[0]), .o_fwr(fw),
    .o_fwr_addr(fa), .o_fwr_data(wd), .o_flag_wr(fl), .o_carry(oc), .o_digit_carry_flag(od),
    .o_zero(oz), .o_wreg(ow), .o_dir_a(ta), .o_dir_b(tb));
  bas_file_model i_bas_file_model (.i_mclk(c), .i_fwr(fw), .i_flag_wr(fl), .i_faddr(a),
    .i_fwr_addr(fa), .i_fwr_data(wd), .i_flags({oc, od, oz}), .o_fdata(fd), .o_flags(fg));
  initial forever #20 c = ~c;
  // one op at the next rising edge, results seen half a cycle later
  task run(input [2:0] o, input [4:0] f, input t, input [7:0] l);
    begin
      @(negedge c);
      {v, op, a, d, k} = {1'b1, o, f, t, l};
      @(negedge c);
      v = 0;
    end
  endtask
  task chk(input [23:0] n, input [7:0] e, input [7:0] g);
    begin
      check_count = check_count + 1;
      if (e !== g) begin
        bad_count = bad_count + 1;
        $display("ERROR %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task t_sub;
    begin
      run(5, 0, 0, 8'h03);
      run(1, 10, 1, 8'h00);
      chk("sub", 8'h6f, wd);
      chk("flg", 8'h04, {oc, od, oz});
      chk("fwr", 8'h01, fw);
      chk("fad", 8'h0a, fa);
      chk("flw", 8'h01, fl);
      run(1, 1, 0, 8'h00);
      chk("wrg", 8'h22, ow);
      chk("fwn", 8'h00, fw);
    end
  endtask
  task t_rot;
    begin
      run(2, 2, 0, 8'h00);
      chk("rot", 8'ha5, ow);
      chk("flg", 8'h02, {oc, od, oz});
      run(3, 3, 1, 8'h00);
      chk("swp", 8'hf6, wd);
      chk("flg", 8'h02, {oc, od, oz});
    end
  endtask
  task t_xor;
    begin
      run(4, 5, 0, 8'h00);
      run(4, 6, 0, 8'h00);
      chk("dra", 8'ha5, ta);
      chk("drb", 8'hff, tb);
      run(5, 0, 0, 8'ha5);
      chk("xlw", 8'h00, ow);
      chk("zro", 8'h01, oz);
      run(6, 4, 0, 8'h00);
      chk("xfw", 8'h94, ow);
      chk("flg", 8'h02, {oc, od, oz});
    end
  endtask
  task report_and_stop;
    begin
      $display("mismatches %0d of %0d checks", bad_count, check_count);
      if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    #120 r = 1;
    repeat (3) @(negedge c);
    t_sub;
    t_rot;
    t_xor;
    report_and_stop;
  end
  // cut a hang short
  initial begin
    #20000 bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule
